// *** inc/pwm_timer_map.vh ***
// register map, field positions, reset values and response codes of the three-channel pwm timer core
// assumes a 32-bit axi4-lite slave, byte addresses, one aligned word per register
// Function
// - timer clock is module clock over 1..128, optionally further divided by 256
// - period, compares, passive selects and levels written to shadows; reads show used values, compare shadow addresses read back shadows
// - enabled shadow transfer happens at zero, and at period match counting up in center mode
// - stopped timer transfers at once; enable bit clears itself after every transfer
// - counter writable only when stopped; clear command zeroes counter, run bit untouched
// - start pin edge (rise, fall, both) sets run bit; field 00 disables hardware start
// - software run-set and run-clear commands set or clear the run bit
// - single-shot clears run at period match edge mode, or one-match down in center mode
// - edge mode counts up only, clears at period match, then pending shadow transfer
// - center mode turns down at period match and up at one-match counting down
// - prescaler held in reset whenever timer is not running
// - compare state ANDed with other modulation and trap states, active as one
// - compare state active on match counting up, passive on match counting down
// - zero match counting up makes passive, unless compare also matches, then active
// - compare switching only while running; stopped counter writes cause no compare action
// - three compares evaluated in parallel; active compares read-only, changed by transfer only
// - state bit set by software set, enabled compare set event while running, hall set event, or capture
// - state bit cleared by software clear, enabled compare reset, single-shot end whatever the reset enable, hysteresis
// - outputs passive while state equals passive select; passive level from level bits
// - hysteresis mode 1001 allows setting state only while position input is high
// - hall mode 1000 lets timer drive state bits of channels 1 and 2 on interval
// - effective set or reset of a channel makes a dead-time reload strobe on real change
// - dead-time counter reloads only at zero and delays only passive-to-active edge
`ifndef PWM_TIMER_MAP_VH
`define PWM_TIMER_MAP_VH

`define ADDR_CTRL      8'h00
`define ADDR_CMD       8'h04
`define ADDR_COUNTER   8'h08
`define ADDR_PERIOD    8'h0C
`define ADDR_CMP0      8'h10
`define ADDR_CMP1      8'h14
`define ADDR_CMP2      8'h18
`define ADDR_CMP0_SH   8'h1C
`define ADDR_CMP1_SH   8'h20
`define ADDR_CMP2_SH   8'h24
`define ADDR_OUTCFG    8'h28
`define ADDR_MODE      8'h2C
`define ADDR_STATUS    8'h30
`define ADDR_DEADTIME  8'h34

// ctrl fields
`define CTRL_CLKSEL_LSB   0
`define CTRL_PRE256_BIT   3
`define CTRL_ALIGN_BIT    4
`define CTRL_SSHOT_BIT    5
`define CTRL_EDGE_LSB     6
`define CTRL_SETEN_BIT    8
`define CTRL_RSTEN_BIT    9
`define CTRL_RESET        32'h0000_0300

// command bits, write one to act
`define CMD_RUN_SET       0
`define CMD_RUN_CLR       1
`define CMD_CNT_CLR       2
`define CMD_XFER_EN       3
`define CMD_SSET_LSB      4
`define CMD_SCLR_LSB      8

// outcfg fields: main passive sel [2:0], compl passive sel [6:4], main level [10:8], compl level [14:12]
`define OUT_MPS_LSB       0
`define OUT_CPS_LSB       4
`define OUT_MPL_LSB       8
`define OUT_CPL_LSB       12

// mode codes per channel, 4 bits each at 4*ch
`define MODE_HALL         4'h8
`define MODE_HYST         4'h9

`define PERIOD_RESET      16'hFFFF
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** verilog/pwm_prescaler.v ***
// prescaler: one-cycle count enable at module clock over 2^sel, optionally over 256 more
// assumes held in reset by its clear input whenever the timer stops
`timescale 1ns/10ps
module pwm_prescaler (
	// clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// control
	input  wire       clear,
	input  wire [2:0] div_sel,
	input  wire       div256,
	// enable out
	output reg        tick
);
	reg  [14:0] cnt_q;
	wire [14:0] limit;
	wire [14:0] base;

	assign base  = (15'h0001 << div_sel) - 15'h0001;
	assign limit = div256 ? ((base << 8) | 15'h00FF) : base;

	always @(posedge aclk) begin
		if (!aresetn || clear) begin
			cnt_q <= 15'h0000;
			tick  <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q <= 15'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 15'h0001;
			tick  <= 1'b0;
		end
	end
endmodule // pwm_prescaler

// *** verilog/pwm_deadtime.v ***
// dead-time counter of one channel: delays only the passive-to-active edge
// assumes reload strobe from a real compare state change and the timer clock enable
`timescale 1ns/10ps
module pwm_deadtime #(
	parameter W = 8
) (
	// clock and reset
	input  wire         aclk,
	input  wire         aresetn,
	// control
	input  wire         tick,
	input  wire         reload,
	input  wire [W-1:0] dt_value,
	input  wire         state_in,
	// delayed state
	output reg          state_out
);
	reg [W-1:0] cnt_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q     <= {W{1'b0}};
			state_out <= 1'b0;
		end else begin
			if (reload && cnt_q == {W{1'b0}})
				cnt_q <= dt_value;
			else if (tick && cnt_q != {W{1'b0}})
				cnt_q <= cnt_q - 1'b1;
			if (!state_in)
				state_out <= 1'b0;
			else if (cnt_q == {W{1'b0}} && !reload)
				state_out <= 1'b1;
		end
	end
endmodule // pwm_deadtime

// *** verilog/pwm_timer_core.v ***
// three-channel pwm timer core: 16-bit counter, three compare channels, shadow transfer
// assumes an axi4-lite master on aclk and synchronous pins; trap, modulation and capture come in as levels
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pwm_timer_map.vh"
module pwm_timer_core #(
	parameter CW = 16,
	parameter DW = 8
) (
	// clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// axi4-lite write address
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output wire          s_axi_awready,
	// axi4-lite write data
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output wire          s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output wire          s_axi_arready,
	// axi4-lite read data
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	// pins and neighbour states
	input  wire          ext_start_pin,
	input  wire [2:0]    position_input,
	input  wire [2:0]    capture_event,
	input  wire [2:0]    hall_set_event,
	input  wire [2:0]    hyst_reset_event,
	input  wire [2:0]    modulation_state,
	input  wire          emergency_stop_input,
	// outputs
	output reg  [2:0]    channel_main_output,
	output reg  [2:0]    channel_compl_output,
	output wire [2:0]    channel_compare_state,
	output wire [2:0]    state_change_strobe,
	output wire          timer_run_bit
);
	// registers
	reg  [31:0]   ctrl_q;
	reg  [11:0]   mode_q;
	reg  [DW-1:0] dt_q;
	reg           run_q;
	reg           dir_q;
	reg           xfer_en_q;
	reg  [CW-1:0] cnt_q;
	reg  [CW-1:0] period_q, period_sh_q;
	reg  [CW-1:0] cmp_q [0:2];
	reg  [CW-1:0] cmp_sh_q [0:2];
	reg  [15:0]   outcfg_q, outcfg_sh_q;
	reg  [2:0]    state_q;
	reg           pin_q;
	// axi
	reg           aw_q, w_q;
	reg  [7:0]    awaddr_q;
	reg  [31:0]   wdata_q;

	wire       center = ctrl_q[`CTRL_ALIGN_BIT];
	wire       sshot  = ctrl_q[`CTRL_SSHOT_BIT];
	wire [1:0] edge_sel = ctrl_q[`CTRL_EDGE_LSB+1:`CTRL_EDGE_LSB];
	wire       tick;

	pwm_prescaler u_pre (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (!run_q),
		.div_sel (ctrl_q[`CTRL_CLKSEL_LSB+2:`CTRL_CLKSEL_LSB]),
		.div256  (ctrl_q[`CTRL_PRE256_BIT]),
		.tick    (tick)
	);

	// write channel: accept address and data in any order, answer after both
	wire wr_go = aw_q && w_q && !s_axi_bvalid;
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `ADDR_DEADTIME);
		end
	endfunction

	// four mode bits per channel
	function mode_is;
		input [11:0] modes;
		input integer chan;
		input [3:0]  code;
		begin
			mode_is = modes[4*chan +: 4] == code;
		end
	endfunction

	// a line drives its passive level, or the inverse of it while active
	function drive_level;
		input on;
		input passive_lvl;
		begin
			drive_level = on ? !passive_lvl : passive_lvl;
		end
	endfunction

	wire       wr_ok  = wr_go && mapped(awaddr_q);
	wire [7:0] wa     = awaddr_q;
	wire       cmd_wr = wr_ok && wa == `ADDR_CMD;
	wire [31:0] cmd   = cmd_wr ? wdata_q : 32'h0000_0000;

	// counter events
	wire period_m = cnt_q == period_q;
	wire one_m    = cnt_q == {{(CW-1){1'b0}}, 1'b1};
	wire step     = run_q && tick;
	wire end_edge = step && !center && period_m;
	wire turn_dn  = step && center && !dir_q && period_m;
	wire turn_up  = step && center && dir_q && one_m;
	wire at_zero  = end_edge || turn_up;
	wire sshot_end = sshot && (end_edge || turn_up);
	wire xfer = xfer_en_q && (!run_q || at_zero || turn_dn);

	// pin edge detect
	wire pin_rise = ext_start_pin && !pin_q;
	wire pin_fall = !ext_start_pin && pin_q;
	wire hw_start = (edge_sel == 2'b01 && pin_rise) || (edge_sel == 2'b10 && pin_fall)
		|| (edge_sel == 2'b11 && (pin_rise || pin_fall));

	// next counter value, used for compare decisions on the step
	reg [CW-1:0] cnt_next;
	always @* begin
		cnt_next = cnt_q;
		if (step) begin
			if (!center)
				cnt_next = period_m ? {CW{1'b0}} : cnt_q + 1'b1;
			else if (!dir_q)
				cnt_next = period_m ? cnt_q - 1'b1 : cnt_q + 1'b1;
			else
				cnt_next = cnt_q - 1'b1; // down through one to zero, so the zero-match exists here too
		end
	end
	wire dir_next = turn_dn ? 1'b1 : (turn_up ? 1'b0 : dir_q);

	// per-channel state bits
	wire [2:0] set_ev, rst_ev;
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
			wire       hyst = mode_is(mode_q, ch, `MODE_HYST);
			wire       cm   = step && cnt_next == cmp_q[ch];
			wire       zm   = step && cnt_next == {CW{1'b0}} && !dir_next;
			// single-shot end clears every state, so the zero-match of that same step must not set one again
			wire       c_set = ctrl_q[`CTRL_SETEN_BIT] && !sshot_end
				&& ((cm && !dir_next) || (zm && cm));
			wire       c_rst = (ctrl_q[`CTRL_RSTEN_BIT] && ((cm && dir_next) || (zm && !cm))) || sshot_end;
			wire       h_set = mode_is(mode_q, ch, `MODE_HALL) && (ch != 0) && hall_set_event[ch];
			wire       pos_ok = !hyst || position_input[ch];
			wire       hy_rst = hyst && (!position_input[ch] || hyst_reset_event[ch]);
			assign set_ev[ch] = !state_q[ch] && pos_ok && (cmd[`CMD_SSET_LSB+ch] || c_set || h_set
				|| capture_event[ch]);
			assign rst_ev[ch] = state_q[ch] && (cmd[`CMD_SCLR_LSB+ch] || c_rst || hy_rst);
		end
	endgenerate
	assign state_change_strobe = set_ev | rst_ev;
	assign channel_compare_state = state_q;
	assign timer_run_bit = run_q;

	// dead-time delayed states and output shaping
	wire [2:0] dly;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_dt
			pwm_deadtime #(.W(DW)) u_dt (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.tick      (tick),
				.reload    (state_change_strobe[ch]),
				.dt_value  (dt_q),
				.state_in  (state_q[ch]),
				.state_out (dly[ch])
			);
			// combined state: active only when every source is active
			wire on_m = (dly[ch] ^ outcfg_q[`OUT_MPS_LSB+ch]) && modulation_state[ch]
				&& !emergency_stop_input;
			// complementary line follows the undelayed state; only its own passive select inverts it
			wire on_c = (state_q[ch] ^ outcfg_q[`OUT_CPS_LSB+ch]) && modulation_state[ch]
				&& !emergency_stop_input;
			always @(posedge aclk) begin
				if (!aresetn) begin
					channel_main_output[ch]  <= 1'b0;
					channel_compl_output[ch] <= 1'b0;
				end else begin
					channel_main_output[ch]  <= drive_level(on_m, outcfg_q[`OUT_MPL_LSB+ch]);
					channel_compl_output[ch] <= drive_level(on_c, outcfg_q[`OUT_CPL_LSB+ch]);
				end
			end
		end
	endgenerate

	// main sequential
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `CTRL_RESET;
			mode_q <= 12'h000;
			dt_q   <= {DW{1'b0}};
			run_q  <= 1'b0;
			dir_q  <= 1'b0;
			xfer_en_q <= 1'b0;
			cnt_q  <= {CW{1'b0}};
			period_q <= `PERIOD_RESET;
			period_sh_q <= `PERIOD_RESET;
			outcfg_q <= 16'h0000;
			outcfg_sh_q <= 16'h0000;
			state_q <= 3'b000;
			pin_q  <= 1'b0;
			aw_q   <= 1'b0;
			w_q    <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			for (i = 0; i < 3; i = i + 1) begin
				cmp_q[i] <= {CW{1'b0}};
				cmp_sh_q[i] <= {CW{1'b0}};
			end
		end else begin
			pin_q <= ext_start_pin;
			// axi write capture
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// register writes; shadow copies only for transferred values
			if (wr_ok) begin
				case (wa)
					`ADDR_CTRL:     ctrl_q <= wdata_q & 32'h0000_03FF;
					`ADDR_PERIOD:   period_sh_q <= wdata_q[CW-1:0];
					`ADDR_CMP0_SH:  cmp_sh_q[0] <= wdata_q[CW-1:0];
					`ADDR_CMP1_SH:  cmp_sh_q[1] <= wdata_q[CW-1:0];
					`ADDR_CMP2_SH:  cmp_sh_q[2] <= wdata_q[CW-1:0];
					`ADDR_OUTCFG:   outcfg_sh_q <= wdata_q[15:0] & 16'h7777;
					`ADDR_MODE:     mode_q <= wdata_q[11:0];
					`ADDR_DEADTIME: dt_q <= wdata_q[DW-1:0];
					default: ;
				endcase
			end
			// counter
			if (cmd[`CMD_CNT_CLR])
				cnt_q <= {CW{1'b0}};
			else if (wr_ok && wa == `ADDR_COUNTER && !run_q)
				cnt_q <= wdata_q[CW-1:0];
			else
				cnt_q <= cnt_next;
			dir_q <= center ? dir_next : 1'b0;
			// run bit: stop wins over start in the same cycle
			if (cmd[`CMD_RUN_CLR] || sshot_end)
				run_q <= 1'b0;
			else if (cmd[`CMD_RUN_SET] || hw_start)
				run_q <= 1'b1;
			// shadow transfer
			if (xfer) begin
				period_q <= period_sh_q;
				outcfg_q <= outcfg_sh_q;
				for (i = 0; i < 3; i = i + 1)
					cmp_q[i] <= cmp_sh_q[i];
			end
			if (cmd[`CMD_XFER_EN])
				xfer_en_q <= 1'b1;
			else if (xfer)
				xfer_en_q <= 1'b0;
			state_q <= (state_q | set_ev) & ~rst_ev;
			// axi read
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
				case (s_axi_araddr)
					`ADDR_CTRL:     s_axi_rdata <= ctrl_q;
					`ADDR_COUNTER:  s_axi_rdata <= {16'h0000, cnt_q};
					`ADDR_PERIOD:   s_axi_rdata <= {16'h0000, period_q};
					`ADDR_CMP0:     s_axi_rdata <= {16'h0000, cmp_q[0]};
					`ADDR_CMP1:     s_axi_rdata <= {16'h0000, cmp_q[1]};
					`ADDR_CMP2:     s_axi_rdata <= {16'h0000, cmp_q[2]};
					`ADDR_CMP0_SH:  s_axi_rdata <= {16'h0000, cmp_sh_q[0]};
					`ADDR_CMP1_SH:  s_axi_rdata <= {16'h0000, cmp_sh_q[1]};
					`ADDR_CMP2_SH:  s_axi_rdata <= {16'h0000, cmp_sh_q[2]};
					`ADDR_OUTCFG:   s_axi_rdata <= {16'h0000, outcfg_q};
					`ADDR_MODE:     s_axi_rdata <= {20'h00000, mode_q};
					`ADDR_STATUS:   s_axi_rdata <= {26'h0000000, state_q, xfer_en_q, dir_q, run_q};
					`ADDR_DEADTIME: s_axi_rdata <= {{(32-DW){1'b0}}, dt_q};
					default:        s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // pwm_timer_core

// *** test/pwm_timer_core_checker.sv ***
// checker: bus answers, run start causes and compare state changes of the core
// assumes it is bound to pwm_timer_core; one clock, synchronous active-low reset
`timescale 1ns/10ps
module pwm_timer_core_checker (
	// clock and reset
	input wire       aclk,
	input wire       aresetn,
	// register bus
	input wire       s_axi_awvalid,
	input wire       s_axi_awready,
	input wire       s_axi_wvalid,
	input wire       s_axi_wready,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	// pins
	input wire       ext_start_pin,
	input wire [2:0] capture_event,
	input wire [2:0] hall_set_event,
	input wire [2:0] hyst_reset_event,
	// states and outputs
	input wire [2:0] channel_compare_state,
	input wire [2:0] state_change_strobe,
	input wire       timer_run_bit,
	input wire [2:0] channel_main_output
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// five quiet cycles cover the start pin edge register and a write still in flight
	sequence no_start_cause;
		(!s_axi_awvalid && !s_axi_bvalid && $stable(ext_start_pin))[*5];
	endsequence
	chk_reset_idle:
		assert property (disable iff (1'b0) !aresetn |=> !timer_run_bit && channel_compare_state == 3'h0
			&& channel_main_output == 3'h0) else $error("core not idle after reset");
	chk_write_answer:
		assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write response late");
	chk_write_release:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
	chk_read_answer:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
	chk_strobe_flips:
		assert property (state_change_strobe != 3'h0 |=> channel_compare_state ==
			$past(channel_compare_state ^ state_change_strobe)) else $error("strobe without state change");
	chk_change_strobed:
		assert property ($past(aresetn) && channel_compare_state != $past(channel_compare_state)
			|-> $past(state_change_strobe) != 3'h0) else $error("state change without strobe");
	chk_stopped_hold:
		assert property (!timer_run_bit && !s_axi_awvalid && !$past(s_axi_awvalid) && !$past(s_axi_awvalid, 2)
			&& !s_axi_bvalid && capture_event == 3'h0 && hall_set_event == 3'h0 && hyst_reset_event == 3'h0
			|=> timer_run_bit || $stable(channel_compare_state)) else $error("state moved while stopped");
	chk_run_cause:
		assert property (no_start_cause ##0 !timer_run_bit |=> !timer_run_bit) else $error("run set without cause");
endmodule // pwm_timer_core_checker

// *** test/power_stage_model.sv ***
// power stage model: counts switch-on edges of the channel 0 high-side switch
// assumes the core's outputs drive the gates directly, active high
`timescale 1ns/10ps
module power_stage_model (
	// clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// gate drives
	input  wire [2:0] high_side,
	input  wire [2:0] low_side,
	// observation
	output reg  [7:0] rises
);
	reg [2:0] hs_q;
	// edges are counted, not levels, so a stuck output shows up as a wrong pulse count
	always @(posedge aclk) begin
		hs_q <= high_side;
		if (!aresetn)
			rises <= 8'h00;
		else if (high_side[0] && !hs_q[0])
			rises <= rises + 8'h01;
	end
endmodule // power_stage_model

// *** test/pwm_timer_core_tb.sv ***
// testbench of pwm_timer_core: register bus, timer runs, compare states, outputs
// assumes the map header on the include path and the power stage model
`timescale 1ns/10ps
`include "pwm_timer_map.vh"
module pwm_timer_core_tb;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [7:0]  s_axi_awaddr = 8'h00;
	reg  [7:0]  s_axi_araddr = 8'h00;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'h0;
	reg         s_axi_awvalid = 1'b0;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	reg         ext_start_pin = 1'b0;
	reg  [2:0]  position_input = 3'h0;
	reg  [2:0]  capture_event = 3'h0;
	reg  [2:0]  hall_set_event = 3'h0;
	reg  [2:0]  hyst_reset_event = 3'h0;
	reg  [2:0]  modulation_state = 3'h7;
	reg         emergency_stop_input = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_run_bit;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0]  channel_main_output, channel_compl_output, channel_compare_state, state_change_strobe;
	wire [7:0]  rises;
	reg  [31:0] d;
	reg  [1:0]  r;
	int         num_errors = 0;
	int         tests_run = 0;
	int         cyc = 0;
	pwm_timer_core u_pwm_timer_core (.*);
	power_stage_model u_power_stage_model (.aclk(aclk), .aresetn(aresetn), .high_side(channel_main_output),
		.low_side(channel_compl_output), .rises(rises));
	always #20 aclk = ~aclk;
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hung handshake ends here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			print_verdict;
		end
	end
	task ck(input string n, input [31:0] e, input [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task t_reset;
		rd(`ADDR_CTRL);
		ck("ctrl", `CTRL_RESET, d);
		rd(`ADDR_PERIOD);
		ck("period", 32'hFFFF, d);
		ck("pins", 32'h0, {channel_compl_output, channel_main_output, channel_compare_state, timer_run_bit});
		rd(8'h40);
		ck("unmapped", `RESP_SLVERR, r);
	endtask
	task t_shadow;
		wr(`ADDR_PERIOD, 32'h5);
		wr(`ADDR_CMP0_SH, 32'h2);
		wr(`ADDR_DEADTIME, 32'h0);
		rd(`ADDR_PERIOD);
		ck("period used", 32'hFFFF, d);
		rd(`ADDR_CMP0);
		ck("cmp0 used", 32'h0, d);
		rd(`ADDR_CMP0_SH);
		ck("cmp0 shadow", 32'h2, d);
		wr(`ADDR_CMD, 32'h8);
		rd(`ADDR_PERIOD);
		ck("period moved", 32'h5, d);
		rd(`ADDR_CMP0);
		ck("cmp0 moved", 32'h2, d);
		rd(`ADDR_STATUS);
		ck("xfer bit", 32'h0, d[2]);
		// counter parked on compare 0's value: a compare action while stopped would show
		wr(`ADDR_COUNTER, 32'h2);
		rd(`ADDR_COUNTER);
		ck("counter", 32'h2, d);
		ck("states", 32'h0, channel_compare_state);
		wr(`ADDR_CMD, 32'h4);
		rd(`ADDR_COUNTER);
		ck("counter clear", 32'h0, d);
	endtask
	task t_soft;
		wr(`ADDR_CMD, 32'h20);
		ck("soft set", 32'h2, channel_compare_state);
		wr(`ADDR_CMD, 32'h200);
		ck("soft clear", 32'h0, channel_compare_state);
		wr(`ADDR_MODE, 32'h9);
		wr(`ADDR_CMD, 32'h10);
		ck("hyst low", 32'h0, channel_compare_state);
		position_input <= 3'h1;
		wr(`ADDR_CMD, 32'h10);
		ck("hyst high", 32'h1, channel_compare_state);
		wr(`ADDR_CMD, 32'h100);
		wr(`ADDR_MODE, 32'h0);
	endtask
	task t_outcfg;
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_OUTCFG, ((i & 1) | ((i & 2) << 7)) * 32'h11);
			wr(`ADDR_CMD, 32'h8);
			repeat (3) @(posedge aclk);
			ck("main level", i[0] ^ i[1], channel_main_output[0]);
			ck("compl level", i[0] ^ i[1], channel_compl_output[0]);
		end
		wr(`ADDR_OUTCFG, 32'h0);
		wr(`ADDR_CMD, 32'h8);
	endtask
	task ev(input [2:0] c, input [2:0] h, input [2:0] y);
		@(posedge aclk);
		capture_event <= c;
		hall_set_event <= h;
		hyst_reset_event <= y;
		@(posedge aclk);
		capture_event <= 3'h0;
		hall_set_event <= 3'h0;
		hyst_reset_event <= 3'h0;
		@(posedge aclk);
	endtask
	// timer stopped: ch0 hysteresis, ch2 hall, so each event reaches only its own channels
	task t_inputs;
		wr(`ADDR_MODE, 32'h809);
		ev(3'h3, 3'h0, 3'h0);
		ck("capture set", 32'h3, channel_compare_state);
		ev(3'h0, 3'h7, 3'h0);
		ck("hall set", 32'h7, channel_compare_state);
		ev(3'h0, 3'h0, 3'h7);
		ck("hyst reset", 32'h6, channel_compare_state);
		modulation_state <= 3'h5;
		repeat (3) @(posedge aclk);
		ck("and main", 32'h4, channel_main_output);
		ck("and compl", 32'h4, channel_compl_output);
		emergency_stop_input <= 1'b1;
		repeat (3) @(posedge aclk);
		ck("trap", 32'h0, channel_main_output | channel_compl_output);
		modulation_state <= 3'h7;
		emergency_stop_input <= 1'b0;
		wr(`ADDR_CMD, 32'h700);
		wr(`ADDR_MODE, 32'h0);
	endtask
	task t_single(input [31:0] c, input int n, input int t, input [7:0] er);
		int k;
		reg [7:0] r0;
		r0 = rises;
		wr(`ADDR_CMD, 32'h4);
		wr(`ADDR_CTRL, c);
		wr(`ADDR_CMD, 32'h1);
		k = 0;
		while (timer_run_bit !== 1'b0) begin
			@(posedge aclk);
			k++;
		end
		ck("shot length", 1'b1, k >= n - 2 && k <= n + 2 * t + 4);
		ck("end states", 32'h0, channel_compare_state);
		ck("pulses", er, rises - r0);
	endtask
	task t_ext;
		for (int s = 0; s < 4; s++) begin
			ext_start_pin <= (s == 2);
			wr(`ADDR_CTRL, 32'h300 | (s << 6));
			repeat (3) @(posedge aclk);
			ext_start_pin <= ~ext_start_pin;
			repeat (6) @(posedge aclk);
			ck("pin start", s != 0, timer_run_bit);
			wr(`ADDR_CMD, 32'h2);
		end
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_shadow;
		t_soft;
		t_outcfg;
		t_inputs;
		t_single(32'h320, 5, 1, 8'h1);
		t_single(32'h322, 20, 4, 8'h1);
		t_single(32'h328, 1280, 256, 8'h1);
		t_single(32'h330, 9, 1, 8'h1);
		wr(`ADDR_CMP0_SH, 32'h6);
		wr(`ADDR_CMD, 32'h8);
		t_single(32'h320, 5, 1, 8'h0);
		wr(`ADDR_CTRL, 32'h300);
		wr(`ADDR_CMD, 32'h1);
		wr(`ADDR_COUNTER, 32'hFFF0);
		rd(`ADDR_COUNTER);
		ck("busy write", 1'b1, d <= 32'h5);
		wr(`ADDR_CMD, 32'h3);
		ck("run clear", 32'h0, timer_run_bit);
		t_ext;
		wr(`ADDR_CMD, 32'h1);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		print_verdict;
	end
endmodule // pwm_timer_core_tb
bind pwm_timer_core pwm_timer_core_checker u_pwm_timer_core_checker (.*);
